// *** twmr_pkg.sv ***
package twmr_pkg;

    // Timing
    localparam int         CLK_PERIOD_NS = 5;
    localparam int         BIT_TIME_NS   = 10000;
    localparam int         QTR_CYC       = (BIT_TIME_NS + 4 * CLK_PERIOD_NS - 1)
                                           / (4 * CLK_PERIOD_NS);
    localparam logic [9:0] QTR_LAST      = 10'(QTR_CYC - 1);

    // Register map
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STAT = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;

    // Control bit positions
    localparam int CB_FLAG = 7;
    localparam int CB_EA   = 6;
    localparam int CB_STA  = 5;
    localparam int CB_STO  = 4;
    localparam int CB_EN   = 2;
    localparam int CB_IE   = 0;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'hff;

    // Status codes
    localparam logic [7:0] SC_START   = 8'h08;
    localparam logic [7:0] SC_RESTART = 8'h10;
    localparam logic [7:0] SC_W_ACK   = 8'h18;
    localparam logic [7:0] SC_W_NACK  = 8'h20;
    localparam logic [7:0] SC_ARB     = 8'h38;
    localparam logic [7:0] SC_R_ACK   = 8'h40;
    localparam logic [7:0] SC_R_NACK  = 8'h48;
    localparam logic [7:0] SC_D_ACK   = 8'h50;
    localparam logic [7:0] SC_D_NACK  = 8'h58;
    localparam logic [7:0] SC_IDLE    = 8'hf8;

    // Bit engine
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [1:0] PH_0     = 2'h0;
    localparam logic [1:0] PH_1     = 2'h1;
    localparam logic [1:0] PH_2     = 2'h2;
    localparam logic [1:0] PH_3     = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_BUSWAIT = 3'b001,
        S_START   = 3'b010,
        S_BIT     = 3'b011,
        S_HOLD    = 3'b100,
        S_STOP    = 3'b101
    } twmr_state_t;

endpackage

// *** twmr_top.sv ***
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module twmr_top
    import twmr_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Register port
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_we_i,
    input  wire logic       reg_re_i,
    output logic      [7:0] reg_rdata_o,
    // Two-wire bus
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_n_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o
);

    typedef struct packed {
        twmr_state_t state;
        logic [1:0]  phase;
        logic [9:0]  qcnt;
        logic [3:0]  bitcnt;
        logic [7:0]  shreg;
        logic        op;
        logic        rd;
        logic        ackv;
        logic        ackok;
        logic        own;
        logic        busy;
        logic        flag;
        logic        ea;
        logic        sta;
        logic        sto;
        logic        wc;
        logic        en;
        logic        ie;
        logic [1:0]  presc;
        logic [7:0]  status;
        logic [7:0]  data;
        logic [7:0]  rdata;
        logic        scl_oe_n;
        logic        sda_oe_n;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_s3;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_s3;
    } twmr_reg_t;

    twmr_reg_t r;
    twmr_reg_t next_r;
    logic      hi_wait;
    logic      run;
    logic      tick;

    function automatic logic is_addr_code(input logic [7:0] s);
        is_addr_code = (s == SC_START) || (s == SC_RESTART);
    endfunction

    function automatic logic is_rx_code(input logic [7:0] s);
        is_rx_code = (s == SC_R_ACK) || (s == SC_D_ACK);
    endfunction

    // First phase after SCL is released; a slave may stretch it
    assign hi_wait = ((r.state == S_BIT) && (r.phase == PH_2))
                  || ((r.state == S_START) && (r.phase == PH_1))
                  || ((r.state == S_STOP) && (r.phase == PH_1));
    assign run     = ((r.state == S_BIT) || (r.state == S_START) || (r.state == S_STOP))
                  && (!hi_wait || r.scl_s2);
    assign tick    = run && (r.qcnt == QTR_LAST);

    always_comb
    begin
        next_r = r;
        next_r.rdata = 8'h00;
        next_r.scl_s1 = scl_i;
        next_r.scl_s2 = r.scl_s1;
        next_r.scl_s3 = r.scl_s2;
        next_r.sda_s1 = sda_i;
        next_r.sda_s2 = r.sda_s1;
        next_r.sda_s3 = r.sda_s2;
        // Any master's START or STOP marks the bus busy or free
        if (r.scl_s2 && r.scl_s3 && r.sda_s3 && !r.sda_s2)
            next_r.busy = 1'b1;
        if (r.scl_s2 && r.scl_s3 && !r.sda_s3 && r.sda_s2)
            next_r.busy = 1'b0;
        if (run)
            next_r.qcnt = tick ? 10'h000 : r.qcnt + 10'h001;

        if (reg_re_i)
        begin
            case (reg_addr_i)
                REG_CTRL: next_r.rdata = {r.flag, r.ea, r.sta, r.sto, r.wc, r.en, 1'b0, r.ie};
                REG_STAT: next_r.rdata = {r.status[7:3], 1'b0, r.presc};
                REG_DATA: next_r.rdata = r.data;
                default:  next_r.rdata = 8'h00;
            endcase
        end

        // Software writes first so a hardware set below wins
        if (reg_we_i)
        begin
            case (reg_addr_i)
                REG_CTRL:
                begin
                    if (reg_wdata_i[CB_FLAG])
                        next_r.flag = 1'b0;
                    next_r.ea  = reg_wdata_i[CB_EA];
                    next_r.sta = reg_wdata_i[CB_STA];
                    next_r.sto = reg_wdata_i[CB_STO];
                    next_r.en  = reg_wdata_i[CB_EN];
                    next_r.ie  = reg_wdata_i[CB_IE];
                end
                REG_STAT: next_r.presc = reg_wdata_i[1:0];
                REG_DATA:
                begin
                    // Data may only change while the engine is parked
                    if (r.flag)
                    begin
                        next_r.data = reg_wdata_i;
                        next_r.wc   = 1'b0;
                    end
                    else
                        next_r.wc = 1'b1;
                end
                default: next_r.wc = r.wc;
            endcase
        end

        case (r.state)
            S_IDLE:
            begin
                next_r.scl_oe_n = 1'b1;
                next_r.sda_oe_n = 1'b1;
                if (r.en && r.sta)
                    next_r.state = S_BUSWAIT;
            end
            S_BUSWAIT:
            begin
                if (!r.busy)
                begin
                    next_r.state = S_START;
                    next_r.phase = PH_0;
                end
            end
            S_START:
            begin
                if (r.phase == PH_0)
                    next_r.sda_oe_n = 1'b1;
                if (tick)
                begin
                    next_r.phase = r.phase + 2'h1;
                    case (r.phase)
                        PH_0: next_r.scl_oe_n = 1'b1;
                        PH_1: next_r.sda_oe_n = 1'b0;
                        PH_2: next_r.sda_oe_n = 1'b0;
                        default:
                        begin
                            next_r.scl_oe_n = 1'b0;
                            next_r.flag     = 1'b1;
                            next_r.status   = r.own ? SC_RESTART : SC_START;
                            next_r.own      = 1'b1;
                            next_r.state    = S_HOLD;
                        end
                    endcase
                end
            end
            S_BIT:
            begin
                if (r.phase == PH_0)
                begin
                    if (r.bitcnt == BIT_LAST)
                        next_r.sda_oe_n = r.op ? !r.ackv : 1'b1;
                    else
                        next_r.sda_oe_n = r.op ? 1'b1 : r.shreg[7];
                end
                if (tick)
                begin
                    next_r.phase = r.phase + 2'h1;
                    case (r.phase)
                        PH_0: next_r.scl_oe_n = 1'b0;
                        PH_1: next_r.scl_oe_n = 1'b1;
                        PH_2:
                        begin
                            if (r.bitcnt == BIT_LAST)
                                next_r.ackok = !r.sda_s2;
                            else
                                next_r.shreg = {r.shreg[6:0], r.sda_s2};
                            // Released a one but the line reads low: another master won
                            if (!r.op && (r.bitcnt != BIT_LAST) && r.sda_oe_n && !r.sda_s2)
                            begin
                                next_r.state    = S_HOLD;
                                next_r.flag     = 1'b1;
                                next_r.status   = SC_ARB;
                                next_r.own      = 1'b0;
                                next_r.scl_oe_n = 1'b1;
                                next_r.sda_oe_n = 1'b1;
                                next_r.phase    = PH_0;
                            end
                        end
                        default:
                        begin
                            next_r.scl_oe_n = 1'b0;
                            if (r.bitcnt == BIT_LAST)
                            begin
                                // SDA is let go in hold, not on the edge that lowers SCL
                                next_r.state    = S_HOLD;
                                next_r.flag     = 1'b1;
                                if (r.op)
                                begin
                                    next_r.data   = r.shreg;
                                    next_r.status = r.ackv ? SC_D_ACK : SC_D_NACK;
                                end
                                else if (r.rd)
                                    next_r.status = r.ackok ? SC_R_ACK : SC_R_NACK;
                                else
                                    next_r.status = r.ackok ? SC_W_ACK : SC_W_NACK;
                            end
                            else
                                next_r.bitcnt = r.bitcnt + 4'h1;
                        end
                    endcase
                end
            end
            S_HOLD:
            begin
                // One cycle after SCL falls, so no false STOP
                next_r.sda_oe_n = 1'b1;
                if (!r.flag)
                begin
                    next_r.bitcnt = 4'h0;
                    next_r.phase  = PH_0;
                    if (is_addr_code(r.status))
                    begin
                        next_r.shreg = r.data;
                        next_r.rd    = r.data[0];
                        next_r.op    = 1'b0;
                        next_r.state = S_BIT;
                    end
                    else if (is_rx_code(r.status))
                    begin
                        next_r.op    = 1'b1;
                        next_r.ackv  = r.ea;
                        next_r.state = S_BIT;
                    end
                    else if (r.status == SC_ARB)
                        next_r.state = r.sta ? S_BUSWAIT : S_IDLE;
                    else if (r.sta && !r.sto)
                        next_r.state = S_START;
                    else
                        next_r.state = S_STOP;
                end
            end
            S_STOP:
            begin
                if (r.phase == PH_0)
                    next_r.sda_oe_n = 1'b0;
                if (tick)
                begin
                    next_r.phase = r.phase + 2'h1;
                    case (r.phase)
                        PH_0: next_r.scl_oe_n = 1'b1;
                        PH_1: next_r.scl_oe_n = 1'b1;
                        PH_2: next_r.sda_oe_n = 1'b1;
                        default:
                        begin
                            next_r.sto    = 1'b0;
                            next_r.own    = 1'b0;
                            next_r.status = SC_IDLE;
                            // Both bits set: START follows once the bus is free
                            next_r.state  = r.sta ? S_BUSWAIT : S_IDLE;
                        end
                    endcase
                end
            end
            default: next_r.state = S_IDLE;
        endcase

        // Disabling drops the bus mid-frame; no STOP is sent
        if (!r.en)
        begin
            next_r.state    = S_IDLE;
            next_r.phase    = PH_0;
            next_r.qcnt     = 10'h000;
            next_r.own      = 1'b0;
            next_r.scl_oe_n = 1'b1;
            next_r.sda_oe_n = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            r          <= '0;
            r.status   <= SC_IDLE;
            r.data     <= DATA_RST;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
            r.scl_s1   <= 1'b1;
            r.scl_s2   <= 1'b1;
            r.scl_s3   <= 1'b1;
            r.sda_s1   <= 1'b1;
            r.sda_s2   <= 1'b1;
            r.sda_s3   <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign reg_rdata_o = r.rdata;
    assign scl_oe_n_o  = r.scl_oe_n;
    assign sda_oe_n_o  = r.sda_oe_n;
    // Open drain: only ever pulls low
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_release;
        r.state == S_HOLD && !r.flag && r.en;
    endsequence

    AST_START_POSTED: assert property (
        $past(r.state) == S_START && r.state == S_HOLD
        |-> r.flag && (r.status == SC_START || r.status == SC_RESTART))
        else $error("START finished without flag or start code");

    AST_NO_START_BUSY: assert property (
        r.state == S_BUSWAIT && r.busy |=> r.state != S_START)
        else $error("START issued on a busy bus");

    AST_DIR_MODE: assert property (
        seq_release and is_addr_code(r.status)
        |=> r.state == S_BIT && !r.op && r.rd == r.shreg[0])
        else $error("Direction bit not taken from address");

    AST_W1C: assert property (
        reg_we_i && reg_addr_i == REG_CTRL && reg_wdata_i[CB_FLAG] && r.state == S_HOLD
        |=> !r.flag)
        else $error("Writing one did not clear the flag");

    AST_ADDR_CODE: assert property (
        $past(r.state) == S_BIT && r.state == S_HOLD && !$past(r.op) && $past(r.rd)
        |-> r.status == SC_ARB || r.status == SC_R_ACK || r.status == SC_R_NACK)
        else $error("Wrong status after read address");

    AST_RX_BYTE: assert property (
        $past(r.state) == S_BIT && r.state == S_HOLD && r.op
        |-> r.data == r.shreg && (r.status == SC_D_ACK || r.status == SC_D_NACK))
        else $error("Received byte not posted");

    AST_ACK_LINE: assert property (
        r.state == S_BIT && r.op && r.bitcnt == BIT_LAST && r.phase == PH_2
        |-> sda_oe_n_o == !r.ackv)
        else $error("Acknowledge bit does not follow ack enable");

    AST_ARB_RELEASE: assert property (
        seq_release and (r.status == SC_ARB && !r.sta)
        |=> r.state == S_IDLE ##1 scl_oe_n_o && sda_oe_n_o)
        else $error("Bus not released after lost arbitration");

    AST_END_SEQ: assert property (
        seq_release and ((r.status == SC_R_NACK || r.status == SC_D_NACK) && r.sto)
        |=> r.state == S_STOP)
        else $error("STOP not issued");

    AST_STOP_CLR: assert property (
        $past(r.state) == S_STOP && r.state != S_STOP && $past(r.en) |-> !r.sto)
        else $error("Stop request not cleared");

    AST_RESTART_OWN: assert property (
        r.flag && r.status == SC_RESTART |-> r.own && !scl_oe_n_o)
        else $error("Bus not owned after repeated START");

    AST_SCL_HELD: assert property (
        r.state == S_HOLD && r.flag && r.status != SC_ARB |-> !scl_oe_n_o)
        else $error("SCL not held low while flag set");

endmodule // twmr_top

// *** twmr_slave_model.sv ***
`timescale 1ns/1ps
module twmr_slave_model
#(
    parameter logic [6:0] ADDR  = 7'h2a,
    parameter logic [7:0] FIRST = 8'ha5
)
(
    // Wire levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Open-drain pull on SDA
    output logic      sda_pull_o
);
    int         k;
    logic [1:0] phase;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic       hit;
    logic       macked;
    logic       prev_scl;
    logic       prev_sda;

    initial
    begin
        k          = 0;
        phase      = 2'h0;
        shreg      = 8'h00;
        tx         = FIRST;
        hit        = 1'b0;
        macked     = 1'b0;
        sda_pull_o = 1'b0;
        prev_scl   = 1'b1;
        prev_sda   = 1'b1;
    end

    // One process, so bus events are seen in a single fixed order
    always @(scl_i or sda_i)
    begin
        if (scl_i && prev_scl && !sda_i && prev_sda)
        begin
            phase      = 2'h1;
            k          = 0;
            sda_pull_o = 1'b0;
        end
        else if (scl_i && prev_scl && sda_i && !prev_sda)
        begin
            phase      = 2'h0;
            sda_pull_o = 1'b0;
        end
        else if (scl_i && !prev_scl)
        begin
            if (phase == 2'h1 && k < 8)
                shreg = {shreg[6:0], sda_i};
            if (phase == 2'h2 && k == 8)
                macked = !sda_i;
            k = k + 1;
        end
        else if (!scl_i && prev_scl)
        begin
            if (phase == 2'h1 && k == 8)
            begin
                hit        = (shreg[7:1] == ADDR);
                sda_pull_o = hit;
            end
            else if (phase == 2'h1 && k == 9)
            begin
                phase      = (hit && shreg[0]) ? 2'h2 : 2'h0;
                k          = 0;
                sda_pull_o = (phase == 2'h2) && !tx[7];
            end
            else if (phase == 2'h2 && k < 8)
                sda_pull_o = !tx[7 - k];
            else if (phase == 2'h2 && k == 8)
                sda_pull_o = 1'b0;
            else if (phase == 2'h2 && k == 9)
            begin
                // Released after NACK so the master can end the transfer
                tx         = tx + 8'h01;
                k          = 0;
                phase      = macked ? 2'h2 : 2'h0;
                sda_pull_o = macked && !tx[7];
            end
        end
        prev_scl = scl_i;
        prev_sda = sda_i;
    end
endmodule // twmr_slave_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
    import twmr_pkg::*;
;
    localparam logic [6:0] SLV_ADDR = 7'h2a;
    localparam logic [7:0] SLV_DATA = 8'ha5;

    logic       sys_clk_i;
    logic       rst_i;
    logic [1:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic       reg_we_i;
    logic       reg_re_i;
    logic [7:0] reg_rdata_o;
    logic       scl_o;
    logic       scl_oe_n_o;
    logic       sda_o;
    logic       sda_oe_n_o;
    logic       sda_pull;
    logic       other_pull;
    logic       scl_w;
    logic       sda_w;
    int         errors;
    int         tests_run;
    logic [7:0] rd;

    // Pull-ups on both wires; slave and a second master only pull SDA
    assign scl_w = scl_oe_n_o ? 1'b1 : scl_o;
    assign sda_w = (!sda_oe_n_o) ? sda_o : !(sda_pull || other_pull);

    twmr_top i_dut (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_we_i    (reg_we_i),
        .reg_re_i    (reg_re_i),
        .reg_rdata_o (reg_rdata_o),
        .scl_i       (scl_w),
        .scl_o       (scl_o),
        .scl_oe_n_o  (scl_oe_n_o),
        .sda_i       (sda_w),
        .sda_o       (sda_o),
        .sda_oe_n_o  (sda_oe_n_o)
    );

    twmr_slave_model #(.ADDR(SLV_ADDR), .FIRST(SLV_DATA)) i_slave (
        .scl_i      (scl_w),
        .sda_i      (sda_w),
        .sda_pull_o (sda_pull)
    );

    initial
    begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = !sys_clk_i;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Called just after a rising edge; one idle edge keeps strobes single
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_we_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_we_i    <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_re_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_re_i   <= 1'b0;
        #1 d = reg_rdata_o;
        @(posedge sys_clk_i);
    endtask

    task automatic expect_reg(input logic [1:0] a, input logic [7:0] m,
                              input logic [7:0] exp, input string what);
        logic [7:0] v;
        reg_read(a, v);
        check8(v & m, exp, what);
    endtask

    // Polls for the flag; a byte takes about 18000 clocks
    task automatic wait_flag();
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 15000 && v[CB_FLAG] !== 1'b1; i++)
            reg_read(REG_CTRL, v);
        check8({7'h00, v[CB_FLAG]}, 8'h01, "flag set");
    endtask

    task automatic step(input logic [7:0] ctrl, input logic [7:0] stat, input string what);
        reg_write(REG_CTRL, ctrl);
        wait_flag();
        // Prescaler bits masked before comparing codes
        expect_reg(REG_STAT, 8'hf8, stat, what);
        check8({7'h00, scl_oe_n_o}, 8'h00, "scl held low");
    endtask

    initial
    begin
        repeat (100000) @(posedge sys_clk_i);
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        errors      = 0;
        tests_run   = 0;
        rst_i       = 1'b1;
        other_pull  = 1'b0;
        reg_addr_i  = 2'h0;
        reg_wdata_i = 8'h00;
        reg_we_i    = 1'b0;
        reg_re_i    = 1'b0;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        expect_reg(REG_CTRL, 8'hff, 8'h00, "ctrl reset");
        expect_reg(REG_STAT, 8'hff, SC_IDLE, "status reset");
        expect_reg(REG_DATA, 8'hff, DATA_RST, "data reset");
        reg_write(2'h3, 8'h5a);
        expect_reg(2'h3, 8'hff, 8'h00, "unmapped");
        // Data write with flag clear is refused
        reg_write(REG_DATA, 8'h55);
        expect_reg(REG_DATA, 8'hff, DATA_RST, "refused data");
        expect_reg(REG_CTRL, 8'h08, 8'h08, "collision bit");
        // Prescaler bits stay set so every code compare must mask them
        reg_write(REG_STAT, 8'h03);
        expect_reg(REG_STAT, 8'h07, 8'h03, "prescaler bits");
        step(8'ha4, SC_START, "start");
        reg_write(REG_DATA, {SLV_ADDR, 1'b1});
        expect_reg(REG_CTRL, 8'h08, 8'h00, "collision cleared");
        step(8'hc4, SC_R_ACK, "read address ack");
        step(8'hc4, SC_D_ACK, "byte ack");
        expect_reg(REG_DATA, 8'hff, SLV_DATA, "first byte");
        step(8'h84, SC_D_NACK, "byte nack");
        expect_reg(REG_DATA, 8'hff, SLV_DATA + 8'h01, "last byte");
        step(8'ha4, SC_RESTART, "repeated start");
        reg_write(REG_DATA, {SLV_ADDR + 7'h01, 1'b1});
        step(8'h84, SC_R_NACK, "other slave nack");
        reg_write(REG_CTRL, 8'h94);
        rd = SC_R_NACK;
        for (int i = 0; i < 3000 && (rd & 8'hf8) !== SC_IDLE; i++)
            reg_read(REG_STAT, rd);
        expect_reg(REG_STAT, 8'hf8, SC_IDLE, "stop done");
        expect_reg(REG_CTRL, 8'h10, 8'h00, "stop bit cleared");
        check8({6'h00, scl_w, sda_w}, 8'h03, "bus released");
        // A second master holds SDA low, so the first address bit is lost
        step(8'ha4, SC_START, "start again");
        reg_write(REG_DATA, 8'hff);
        other_pull <= 1'b1;
        reg_write(REG_CTRL, 8'h84);
        wait_flag();
        expect_reg(REG_STAT, 8'hf8, SC_ARB, "arbitration lost");
        other_pull <= 1'b0;
        reg_write(REG_CTRL, 8'h84);
        expect_reg(REG_CTRL, 8'h80, 8'h00, "flag cleared after loss");
        check8({6'h00, scl_w, sda_w}, 8'h03, "bus released after loss");
        end_of_test();
    end
endmodule // testbench
